// ===== shared/pmc_regs.vh
// register map, field positions, reset values and timing constants of the power mode controller
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// =====================================================================
// register offsets (byte addresses on the serial register port)
`define PMC_REG_PON 8'h00
`define PMC_REG_BATTERY_LOW_ALARM_REG 8'h04
`define PMC_REG_IRQMASK 8'h08

// =====================================================================
// power on event register fields
`define PMC_PON_ACK_BIT 4
`define PMC_PON_BATTINS_BIT 3
`define PMC_PON_BUTTON_BIT 2
`define PMC_PON_ADAPTER_BIT 1
`define PMC_PON_USB_BIT 0

// =====================================================================
// reset values and codes
`define PMC_BATTERY_LOW_ALARM_REG_RESET 5'h0C
`define PMC_BATTERY_LOW_ALARM_REG_CLAMP 5'h14
`define PMC_IRQMASK_RESET 2'h0
`define PMC_IRQMASK_BATT_BIT 0
`define PMC_IRQMASK_THERM_BIT 1

// =====================================================================
// power button sense codes
`define PMC_SENSE_RISE 2'h0
`define PMC_SENSE_FALL 2'h1
`define PMC_SENSE_HIGH 2'h2
`define PMC_SENSE_LOW 2'h3

// =====================================================================
// serial port slave address (arbitrary value)
`define PMC_I2C_ADDR 7'h3A

// =====================================================================
// timing: clock rate in kHz and times in ms
`define PMC_CLK_KHZ 50000
`define PMC_DEGLITCH_MS 32
`define PMC_ACK_MS 128
`define PMC_BATTERY_LOW_ALARM_REG_MS 5
`define PMC_SYSTEM_RESET_OUT_N_MS 60

// the same times as 24-bit cycle counts at the clock rate above
`define PMC_DEGLITCH_CYC 24'h186A00
`define PMC_ACK_CYC 24'h61A800
`define PMC_BATTERY_LOW_ALARM_REG_CYC 24'h03D090
`define PMC_SYSTEM_RESET_OUT_N_CYC 24'h2DC6C0

`endif

// ===== rtl/pmc_deglitch.v
// stability filter that passes a level only after it has held steady for a set number of cycles
`timescale 1ns/100ps

module pmc_deglitch #(
  parameter [23:0] CYCLES = 24'd1600000
) (
  input wire clk,
  input wire rst_b,
  input wire rawIn,
  output reg cleanOut
);

  // =====================================================================
  // filter
  reg [23:0] stableCnt_reg;

  // restart the count on every bounce, accept once the new level held
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stableCnt_reg <= 24'h000000;
      cleanOut <= 1'b0;
    end else if (rawIn == cleanOut) begin
      stableCnt_reg <= 24'h000000;
    end else if (stableCnt_reg >= CYCLES - 24'd1) begin
      stableCnt_reg <= 24'h000000;
      cleanOut <= rawIn;
    end else begin
      stableCnt_reg <= stableCnt_reg + 24'd1;
    end
  end

endmodule // pmc_deglitch

// ===== rtl/pmc_power_mode_controller.v
// power mode state controller with its serial register port and supply supervision
`timescale 1ns/100ps
`include "pmc_regs.vh"

// Operation
// - active mode enables regulators, converter, port, oscillator, monitor; reset released after counter; charger if supply
// - charger standby: rails off, reset low, port/oscillator/monitor on, charger if supply
// - standby waits for button, adapter or usb wake event, then goes active
// - standby falls to power off when battery is not above lockout level and no external supply is present
// - power off whenever battery is below lockout unless external supply is present
// - battery inserted above low threshold in power off goes straight to active
// - battery inserted below low threshold in power off goes to standby
// - power-on reset holds logic in reset and releases it initialised
// - over-temperature shutdown forces standby mode from active and charger standby, and blocks every wake from power off
// - thermal alarm raises an interrupt request unless masked
// - open-drain active-low system reset, asserted outside active, released by counter
// - host-programmable registers written over the serial port load defaults on reset
// - battery below low threshold for more than 5 ms forces power off from active mode without external supply
// - low battery condition clears only 50 mV above the falling threshold
// - low battery interrupt request raised 200 mV above the power-down threshold
// - threshold field resets to 5'h0C, upper three bits read zero
// - button, adapter and usb wake sources are deglitched for 32 ms before acceptance; battery insertion is not
// - host acknowledge within 128 ms of power-up, otherwise drop to standby, or to charger standby if supply
module pmc_power_mode_controller #(
  parameter [23:0] DEGLITCH_CYC = `PMC_DEGLITCH_CYC,
  parameter [23:0] ACK_CYC = `PMC_ACK_CYC,
  parameter [23:0] BATTERY_LOW_ALARM_REG_CYC = `PMC_BATTERY_LOW_ALARM_REG_CYC,
  parameter [23:0] SYSTEM_RESET_OUT_N_CYC = `PMC_SYSTEM_RESET_OUT_N_CYC,
  parameter [1:0] BUTTON_SENSE = `PMC_SENSE_RISE,
  parameter [6:0] I2C_ADDR = `PMC_I2C_ADDR
) (
  input wire clk,
  input wire rst_b,
  input wire scl,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOeN,
  input wire powerButtonInput,
  input wire adapterPresent,
  input wire usbPresent,
  input wire battAboveUvlo,
  input wire battLowCmp,
  input wire battIrqCmp,
  input wire thermShutdown,
  input wire thermAlarm,
  input wire powerAckPin,
  output reg regulatorEn,
  output reg converterEn,
  output reg chargerEn,
  output reg adcEn,
  output reg i2cEn,
  output reg oscEn,
  output reg battMonEn,
  output reg systemResetOutN,
  output reg systemResetOeN,
  output reg [4:0] battLowThreshold,
  output reg battLowHyst,
  output reg irqBattLow,
  output reg irqThermal,
  output reg [3:0] modeOut
);

  // =====================================================================
  // input synchronisers
  localparam [10:0] SYNC_RESET = 11'h003;
  wire [10:0] asyncIn;
  reg [10:0] syncA_reg;
  reg [10:0] syncB_reg;

  assign asyncIn = {powerAckPin, thermAlarm, thermShutdown, battIrqCmp, battLowCmp, battAboveUvlo,
                    usbPresent, adapterPresent, powerButtonInput, sdaIn, scl};

  // two flops per pin, scl and sda idle high
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_reg <= SYNC_RESET;
      syncB_reg <= SYNC_RESET;
    end else begin
      syncA_reg <= asyncIn;
      syncB_reg <= syncA_reg;
    end
  end

  wire sclS = syncB_reg[0];
  wire sdaS = syncB_reg[1];
  wire battOkS = syncB_reg[5];
  wire battLowS = syncB_reg[6];
  wire battIrqS = syncB_reg[7];
  wire thermS = syncB_reg[8];
  wire alarmS = syncB_reg[9];
  wire ackPinS = syncB_reg[10];

  // =====================================================================
  // wake source filters and battery low filter
  wire [2:0] wakeRaw = syncB_reg[4:2];
  wire [2:0] wakeClean;
  wire battLowFilt;
  genvar gi;

  // one stability filter per wake source
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gWake
      pmc_deglitch #(
        .CYCLES(DEGLITCH_CYC)
      ) uWake (
        .clk(clk),
        .rst_b(rst_b),
        .rawIn(wakeRaw[gi]),
        .cleanOut(wakeClean[gi])
      );
    end
  endgenerate

  // short dips under the threshold never reach the mode machine
  pmc_deglitch #(
    .CYCLES(BATTERY_LOW_ALARM_REG_CYC)
  ) uBattLow (
    .clk(clk),
    .rst_b(rst_b),
    .rawIn(battLowS),
    .cleanOut(battLowFilt)
  );

  wire buttonClean = wakeClean[0];
  wire adapterClean = wakeClean[1];
  wire usbClean = wakeClean[2];
  wire extSupply = adapterClean | usbClean;

  // =====================================================================
  // edge history
  reg buttonPrev_reg;
  reg uvloPrev_reg;
  reg sclPrev_reg;
  reg sdaPrev_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buttonPrev_reg <= 1'b0;
      uvloPrev_reg <= 1'b0;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      buttonPrev_reg <= buttonClean;
      uvloPrev_reg <= battOkS;
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
    end
  end

  // power button event in its configured sense
  reg buttonEvent;
  always @* begin
    case (BUTTON_SENSE)
      `PMC_SENSE_RISE: buttonEvent = buttonClean & ~buttonPrev_reg;
      `PMC_SENSE_FALL: buttonEvent = ~buttonClean & buttonPrev_reg;
      `PMC_SENSE_HIGH: buttonEvent = buttonClean;
      default: buttonEvent = ~buttonClean;
    endcase
  end

  // a battery rising above the lockout level, whether or not an adapter is attached
  wire battInsert = battOkS & ~uvloPrev_reg;

  // =====================================================================
  // mode state machine
  localparam [3:0] M_OFF = 4'b0001;
  localparam [3:0] M_STBY = 4'b0010;
  localparam [3:0] M_ACT = 4'b0100;
  localparam [3:0] M_CHG = 4'b1000;

  reg [3:0] mode_reg;
  reg [3:0] mode_next;
  reg [3:0] wakeSrc;
  reg packBit_reg;
  reg ackSeen_reg;
  reg [23:0] ackCnt_reg;
  reg [23:0] rstCnt_reg;

  wire ackNow = packBit_reg | ackPinS;
  wire ackTimeout = (ackCnt_reg == ACK_CYC);
  wire [3:0] offTarget = extSupply ? M_CHG : M_STBY;

  // next mode; thermal shutdown is tested ahead of every wake
  always @* begin
    mode_next = mode_reg;
    wakeSrc = 4'h0;
    case (mode_reg)
      M_OFF: begin
        if (adapterClean && !thermS) begin
          mode_next = M_ACT;
          wakeSrc[`PMC_PON_ADAPTER_BIT] = 1'b1;
        end else if (battInsert) begin
          if (!battLowFilt && !thermS) begin
            mode_next = M_ACT;
            wakeSrc[`PMC_PON_BATTINS_BIT] = 1'b1;
          end else begin
            mode_next = M_STBY;
          end
        end else if (usbClean && battOkS && !battLowFilt && !thermS) begin
          mode_next = M_ACT;
          wakeSrc[`PMC_PON_USB_BIT] = 1'b1;
        end
      end
      M_STBY: begin
        if (!battOkS && !extSupply) begin
          mode_next = M_OFF;
        end else if (thermS) begin
          mode_next = M_STBY;
        end else if (adapterClean) begin
          mode_next = M_ACT;
          wakeSrc[`PMC_PON_ADAPTER_BIT] = 1'b1;
        end else if (buttonEvent && !battLowFilt) begin
          mode_next = M_ACT;
          wakeSrc[`PMC_PON_BUTTON_BIT] = 1'b1;
        end else if (usbClean && !battLowFilt) begin
          mode_next = M_ACT;
          wakeSrc[`PMC_PON_USB_BIT] = 1'b1;
        end
      end
      M_ACT: begin
        if (thermS) begin
          mode_next = M_STBY;
        end else if (!battOkS && !extSupply) begin
          mode_next = M_OFF;
        end else if (battLowFilt && !extSupply) begin
          mode_next = M_OFF;
        end else if (!ackSeen_reg && ackTimeout) begin
          mode_next = offTarget;
        end else if (ackSeen_reg && !ackNow) begin
          mode_next = offTarget;
        end
      end
      M_CHG: begin
        if (!battOkS && !extSupply) begin
          mode_next = M_OFF;
        end else if (thermS || !extSupply) begin
          mode_next = M_STBY;
        end else if (buttonEvent) begin
          mode_next = M_ACT;
          wakeSrc[`PMC_PON_BUTTON_BIT] = 1'b1;
        end
      end
      default: mode_next = M_OFF;
    endcase
  end

  // starts in power off on the power-on reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= M_OFF;
    end else begin
      mode_reg <= mode_next;
    end
  end

  wire enterActive = (mode_next == M_ACT) && (mode_reg != M_ACT);
  wire leaveActive = (mode_reg == M_ACT) && (mode_next != M_ACT);

  // acknowledge window and reset release counters
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ackSeen_reg <= 1'b0;
      ackCnt_reg <= 24'h000000;
      rstCnt_reg <= 24'h000000;
    end else if (mode_reg != M_ACT) begin
      ackSeen_reg <= 1'b0;
      ackCnt_reg <= 24'h000000;
      rstCnt_reg <= 24'h000000;
    end else begin
      if (ackNow) begin
        ackSeen_reg <= 1'b1;
      end
      if (!ackSeen_reg && !ackTimeout) begin
        ackCnt_reg <= ackCnt_reg + 24'd1;
      end
      if (rstCnt_reg != SYSTEM_RESET_OUT_N_CYC) begin
        rstCnt_reg <= rstCnt_reg + 24'd1;
      end
    end
  end

  // =====================================================================
  // serial register port
  localparam [4:0] I_IDLE = 5'b00001;
  localparam [4:0] I_RX = 5'b00010;
  localparam [4:0] I_ACK = 5'b00100;
  localparam [4:0] I_TX = 5'b01000;
  localparam [4:0] I_RACK = 5'b10000;

  reg [4:0] i2cState_reg;
  reg [3:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg [1:0] byteIdx_reg;
  reg readMode_reg;
  reg nack_reg;
  reg [7:0] ptr_reg;
  reg wrStrobe_reg;
  reg [7:0] wrData_reg;
  reg [3:0] ponSrc_reg;
  reg [4:0] thr_reg;
  reg [1:0] mask_reg;
  reg [7:0] readByte;

  wire sclRise = sclS & ~sclPrev_reg;
  wire sclFall = ~sclS & sclPrev_reg;
  wire startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  wire stopCond = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
  wire portOn = (mode_reg == M_ACT) || (mode_reg == M_CHG);

  // read data at the pointer, reserved bits zero
  always @* begin
    case (ptr_reg)
      `PMC_REG_PON: readByte = {3'h0, packBit_reg, ponSrc_reg};
      `PMC_REG_BATTERY_LOW_ALARM_REG: readByte = {3'h0, thr_reg};
      `PMC_REG_IRQMASK: readByte = {6'h00, mask_reg};
      default: readByte = 8'h00;
    endcase
  end

  // byte framing: address, pointer, then data; oe low pulls sda low
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      i2cState_reg <= I_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byteIdx_reg <= 2'h0;
      readMode_reg <= 1'b0;
      nack_reg <= 1'b0;
      ptr_reg <= 8'h00;
      wrStrobe_reg <= 1'b0;
      wrData_reg <= 8'h00;
      sdaOeN <= 1'b1;
      sdaOut <= 1'b0;
    end else begin
      wrStrobe_reg <= 1'b0;
      if (!portOn || stopCond) begin
        i2cState_reg <= I_IDLE;
        sdaOeN <= 1'b1;
      end else if (startCond) begin
        i2cState_reg <= I_RX;
        bitCnt_reg <= 4'h0;
        byteIdx_reg <= 2'h0;
        readMode_reg <= 1'b0;
        sdaOeN <= 1'b1;
      end else begin
        case (i2cState_reg)
          I_IDLE: i2cState_reg <= I_IDLE;
          I_RX: begin
            if (sclRise && bitCnt_reg != 4'd8) begin
              shift_reg <= {shift_reg[6:0], sdaS};
              bitCnt_reg <= bitCnt_reg + 4'd1;
            end else if (sclFall && bitCnt_reg == 4'd8) begin
              bitCnt_reg <= 4'h0;
              if (byteIdx_reg != 2'd2) begin
                byteIdx_reg <= byteIdx_reg + 2'd1;
              end
              if (byteIdx_reg == 2'd0) begin
                if (shift_reg[7:1] == I2C_ADDR) begin
                  readMode_reg <= shift_reg[0];
                  sdaOeN <= 1'b0;
                  i2cState_reg <= I_ACK;
                end else begin
                  i2cState_reg <= I_IDLE;
                end
              end else begin
                sdaOeN <= 1'b0;
                i2cState_reg <= I_ACK;
                if (byteIdx_reg == 2'd1) begin
                  ptr_reg <= shift_reg;
                end else begin
                  wrStrobe_reg <= 1'b1;
                  wrData_reg <= shift_reg;
                end
              end
            end
          end
          I_ACK: begin
            if (sclFall) begin
              if (readMode_reg) begin
                sdaOeN <= readByte[7];
                shift_reg <= {readByte[6:0], 1'b0};
                bitCnt_reg <= 4'd1;
                i2cState_reg <= I_TX;
              end else begin
                sdaOeN <= 1'b1;
                i2cState_reg <= I_RX;
              end
            end
          end
          I_TX: begin
            if (sclFall) begin
              if (bitCnt_reg == 4'd8) begin
                sdaOeN <= 1'b1;
                i2cState_reg <= I_RACK;
              end else begin
                sdaOeN <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bitCnt_reg <= bitCnt_reg + 4'd1;
              end
            end
          end
          I_RACK: begin
            if (sclRise) begin
              nack_reg <= sdaS;
            end else if (sclFall) begin
              if (nack_reg) begin
                i2cState_reg <= I_IDLE;
              end else begin
                sdaOeN <= readByte[7];
                shift_reg <= {readByte[6:0], 1'b0};
                bitCnt_reg <= 4'd1;
                i2cState_reg <= I_TX;
              end
            end
          end
          default: i2cState_reg <= I_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // register file
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      packBit_reg <= 1'b0;
      ponSrc_reg <= 4'h0;
      thr_reg <= `PMC_BATTERY_LOW_ALARM_REG_RESET;
      mask_reg <= `PMC_IRQMASK_RESET;
    end else begin
      if (leaveActive) begin
        packBit_reg <= 1'b0;
        ponSrc_reg <= 4'h0;
      end else begin
        if (enterActive) begin
          ponSrc_reg <= ponSrc_reg | wakeSrc;
        end
        if (wrStrobe_reg && ptr_reg == `PMC_REG_PON) begin
          packBit_reg <= wrData_reg[`PMC_PON_ACK_BIT];
        end
      end
      if (wrStrobe_reg && ptr_reg == `PMC_REG_BATTERY_LOW_ALARM_REG) begin
        thr_reg <= wrData_reg[4:0];
      end
      if (wrStrobe_reg && ptr_reg == `PMC_REG_IRQMASK) begin
        mask_reg <= wrData_reg[1:0];
      end
    end
  end

  // =====================================================================
  // mode-driven outputs
  wire isAct = (mode_reg == M_ACT);
  wire isChg = (mode_reg == M_CHG);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regulatorEn <= 1'b0;
      converterEn <= 1'b0;
      chargerEn <= 1'b0;
      adcEn <= 1'b0;
      i2cEn <= 1'b0;
      oscEn <= 1'b0;
      battMonEn <= 1'b0;
      systemResetOutN <= 1'b0;
      systemResetOeN <= 1'b0;
      battLowThreshold <= `PMC_BATTERY_LOW_ALARM_REG_RESET;
      battLowHyst <= 1'b0;
      irqBattLow <= 1'b0;
      irqThermal <= 1'b0;
      modeOut <= M_OFF;
    end else begin
      regulatorEn <= isAct;
      converterEn <= isAct;
      adcEn <= isAct;
      chargerEn <= (isAct | isChg) & extSupply;
      i2cEn <= isAct | isChg;
      oscEn <= isAct | isChg;
      battMonEn <= (mode_reg != M_OFF);
      systemResetOutN <= 1'b0;
      // oe low pulls the reset line low outside a settled active mode
      systemResetOeN <= isAct && (rstCnt_reg == SYSTEM_RESET_OUT_N_CYC);
      // codes above the clamp select the clamp code 5'h14
      battLowThreshold <= (thr_reg > `PMC_BATTERY_LOW_ALARM_REG_CLAMP) ? `PMC_BATTERY_LOW_ALARM_REG_CLAMP : thr_reg;
      battLowHyst <= battLowFilt;
      irqBattLow <= battIrqS & (mode_reg != M_OFF) & ~mask_reg[`PMC_IRQMASK_BATT_BIT];
      irqThermal <= alarmS & ~mask_reg[`PMC_IRQMASK_THERM_BIT];
      modeOut <= mode_reg;
    end
  end

endmodule // pmc_power_mode_controller

// ===== rtl/_unused_placeholder_never.v
`timescale 1ns/100ps
// empty

// ===== tb/pmc_asserts.sv
// port checker of the power mode controller
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_asserts #(
  parameter [23:0] SYSTEM_RESET_OUT_N_CYC = `PMC_SYSTEM_RESET_OUT_N_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire thermShutdown,
  input wire thermAlarm,
  input wire regulatorEn,
  input wire converterEn,
  input wire chargerEn,
  input wire adcEn,
  input wire i2cEn,
  input wire oscEn,
  input wire battMonEn,
  input wire systemResetOeN,
  input wire [4:0] battLowThreshold,
  input wire irqThermal,
  input wire [3:0] modeOut
);
  // =====================================================
  // helpers
  logic [23:0] actCnt_reg;
  logic [3:0] prevMode_reg;
  // counts cycles spent in active, remembers last mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      actCnt_reg <= 24'h0;
      prevMode_reg <= 4'h1;
    end else begin
      actCnt_reg <= (modeOut == 4'h4) ? actCnt_reg + 24'h1 : 24'h0;
      prevMode_reg <= modeOut;
    end
  end
  // mode held over two samples, so a one cycle skew is tolerated
  wire inOff = modeOut == 4'h1 && prevMode_reg == 4'h1;
  wire inSb = modeOut == 4'h2 && prevMode_reg == 4'h2;
  wire inAct = modeOut == 4'h4 && prevMode_reg == 4'h4;
  wire inChg = modeOut == 4'h8 && prevMode_reg == 4'h8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_active_rails_on: assert property (inAct |-> regulatorEn && converterEn && adcEn && i2cEn && oscEn && battMonEn)
    else $error("rails not on in active");
  a_chgsb_rails: assert property (inChg |-> !regulatorEn && !converterEn && !adcEn && !systemResetOeN && i2cEn && oscEn && battMonEn)
    else $error("wrong enables in charger standby");
  a_standby_monitor: assert property (inSb |-> battMonEn && !regulatorEn && !i2cEn && !oscEn && !chargerEn)
    else $error("wrong enables in standby");
  a_off_all_dark: assert property (inOff |-> !(regulatorEn | chargerEn | i2cEn | oscEn | battMonEn | adcEn))
    else $error("enable high in power off");
  a_reset_held_low: assert property (modeOut != 4'h4 && prevMode_reg != 4'h4 |-> !systemResetOeN)
    else $error("system reset released outside active");
  a_reset_release_delay: assert property ($rose(systemResetOeN) |-> actCnt_reg + 24'h3 >= SYSTEM_RESET_OUT_N_CYC && actCnt_reg <= SYSTEM_RESET_OUT_N_CYC + 24'h3)
    else $error("system reset released at wrong time");
  a_therm_to_standby: assert property (thermShutdown && modeOut == 4'h4 |-> ##[1:8] modeOut == 4'h2)
    else $error("no standby after thermal shutdown");
  a_therm_irq_cause: assert property ($rose(irqThermal) |-> $past(thermAlarm, 2))
    else $error("thermal irq without alarm");
  a_mode_one_hot: assert property ($onehot(modeOut))
    else $error("mode not one hot");
  a_thresh_clamped: assert property (battLowThreshold <= 5'h14)
    else $error("threshold code beyond clamp");
endmodule // pmc_asserts
bind pmc_power_mode_controller pmc_asserts #(.SYSTEM_RESET_OUT_N_CYC(SYSTEM_RESET_OUT_N_CYC)) u_asserts (.clk, .rst_b, .thermShutdown,
  .thermAlarm, .regulatorEn, .converterEn, .chargerEn, .adcEn, .i2cEn, .oscEn, .battMonEn, .systemResetOeN,
  .battLowThreshold, .irqThermal, .modeOut);

// ===== tb/pmc_host_model.sv
// host processor model driving the serial register port
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_host_model (
  output logic scl,
  output logic sdaOeN,
  input wire sdaIn
);
  // =====================================================
  // bus idles released, clock stands high between frames
  initial begin
    scl = 1;
    sdaOeN = 1;
  end
  // one bit slot: data set in low phase, line sampled midway through high phase
  task automatic bitIo(input logic b, output logic s);
    sdaOeN = b;
    #40 scl = 1;
    #40 s = sdaIn;
    #40 scl = 0;
    #40;
  endtask
  // eight bits msb first, then the acknowledge slot left released
  task automatic byteIo(input logic [7:0] d, output logic [7:0] q, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], q[i]);
    end
    bitIo(1'h1, nack);
  endtask
  task automatic start;
    sdaOeN = 1;
    scl = 1;
    #40 sdaOeN = 0;
    #40 scl = 0;
    #40;
  endtask
  task automatic stop;
    sdaOeN = 0;
    #40 scl = 1;
    #40 sdaOeN = 1;
    #80;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    byteIo({`PMC_I2C_ADDR, 1'h0}, q, n0);
    byteIo(p, q, n1);
    byteIo(v, q, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask
  // pointer write, stop, then one byte read ended by a master nack
  task automatic rd(input logic [7:0] p, output logic [7:0] v, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    byteIo({`PMC_I2C_ADDR, 1'h0}, q, n0);
    byteIo(p, q, n1);
    stop();
    start();
    byteIo({`PMC_I2C_ADDR, 1'h1}, q, n2);
    byteIo(8'hFF, v, n3);
    stop();
    ok = !(n0 | n1 | n2);
  endtask
endmodule // pmc_host_model

// ===== tb/tb.sv
// self-checking testbench of the power mode controller
`timescale 1ns/100ps
`include "pmc_regs.vh"
module tb;
  // =====================================================
  // stimulus and wiring
  logic clk = 0;
  logic rst_b = 0;
  logic btn = 0, adp = 0, usb = 0, uvloOk = 0, lowCmp = 0, irqCmp = 0, tShut = 0, tAlarm = 0, ackPin = 0;
  wire scl, hostOeN, sdaOut, sdaOeN, resetOeN, chgEn, regEn, irqB, irqT, hyst, rstOut;
  wire [4:0] thr;
  wire [3:0] mode;
  wire sdaWire = (sdaOeN | sdaOut) & hostOeN;
  int errTotal = 0, checks = 0, cycleCount = 0;
  logic [7:0] q;
  logic ok;
  always #10 clk = ~clk;
  pmc_power_mode_controller #(.DEGLITCH_CYC(24'd16), .ACK_CYC(24'd2000), .BATTERY_LOW_ALARM_REG_CYC(24'd10),
    .SYSTEM_RESET_OUT_N_CYC(24'd20)) u_dut (.clk(clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .powerButtonInput(btn), .adapterPresent(adp), .usbPresent(usb), .battAboveUvlo(uvloOk),
    .battLowCmp(lowCmp), .battIrqCmp(irqCmp), .thermShutdown(tShut), .thermAlarm(tAlarm),
    .powerAckPin(ackPin), .regulatorEn(regEn), .converterEn(), .chargerEn(chgEn), .adcEn(), .i2cEn(),
    .oscEn(), .battMonEn(), .systemResetOutN(rstOut), .systemResetOeN(resetOeN), .battLowThreshold(thr),
    .battLowHyst(hyst), .irqBattLow(irqB), .irqThermal(irqT), .modeOut(mode));
  pmc_host_model u_host (.scl(scl), .sdaOeN(hostOeN), .sdaIn(sdaWire));
  // =====================================================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic waitMode(input logic [3:0] m);
    for (int i = 0; i < 3000 && mode !== m; i++) cyc(1);
    chk({4'h0, mode}, {4'h0, m});
  endtask
  task automatic wrReg(input logic [7:0] p, input logic [7:0] v);
    u_host.wr(p, v, ok);
    chk({7'h0, ok}, 8'h01);
    cyc(1);
  endtask
  task automatic rdReg(input logic [7:0] p, input logic [7:0] e);
    u_host.rd(p, q, ok);
    chk({7'h0, ok}, 8'h01);
    chk(q, e);
    cyc(1);
  endtask
  task automatic finish_test;
    if (errTotal == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 80000) begin
      errTotal++;
      finish_test();
    end
  end
  // =====================================================
  // main sequence
  initial begin
    cyc(2);
    rst_b = 1;
    chk({4'h0, mode}, 8'h01);
    chk({3'h0, thr}, 8'h0C);
    chk({6'h0, rstOut, resetOeN}, 8'h00);
    uvloOk = 1;
    waitMode(4'h4);
    chk({7'h0, chgEn}, 8'h00);
    wrReg(`PMC_REG_PON, 8'hFF);
    rdReg(`PMC_REG_PON, 8'h18);
    chk({6'h0, rstOut, resetOeN}, 8'h01);
    rdReg(`PMC_REG_BATTERY_LOW_ALARM_REG, 8'h0C);
    wrReg(`PMC_REG_BATTERY_LOW_ALARM_REG, 8'hFF);
    rdReg(`PMC_REG_BATTERY_LOW_ALARM_REG, 8'h1F);
    chk({3'h0, thr}, 8'h14);
    wrReg(`PMC_REG_BATTERY_LOW_ALARM_REG, 8'h05);
    chk({3'h0, thr}, 8'h05);
    wrReg(8'h0C, 8'h5A);
    rdReg(8'h0C, 8'h00);
    // interrupt levels and their masking
    tAlarm = 1;
    irqCmp = 1;
    cyc(6);
    chk({6'h0, irqT, irqB}, 8'h03);
    wrReg(`PMC_REG_IRQMASK, 8'h03);
    chk({6'h0, irqT, irqB}, 8'h00);
    wrReg(`PMC_REG_IRQMASK, 8'h00);
    tAlarm = 0;
    irqCmp = 0;
    // short low battery dip ignored, long one powers off
    lowCmp = 1;
    cyc(6);
    lowCmp = 0;
    cyc(30);
    chk({4'h0, mode}, 8'h04);
    lowCmp = 1;
    cyc(8);
    chk({4'h0, mode}, 8'h04);
    waitMode(4'h1);
    chk({7'h0, hyst}, 8'h01);
    // weak battery inserted lands in standby, lockout drops to off
    uvloOk = 0;
    cyc(20);
    uvloOk = 1;
    waitMode(4'h2);
    uvloOk = 0;
    waitMode(4'h1);
    lowCmp = 0;
    cyc(30);
    chk({7'h0, hyst}, 8'h00);
    uvloOk = 1;
    waitMode(4'h4);
    waitMode(4'h2);
    // button glitch ignored, held press wakes
    btn = 1;
    cyc(8);
    btn = 0;
    cyc(30);
    chk({4'h0, mode}, 8'h02);
    btn = 1;
    waitMode(4'h4);
    ackPin = 1;
    rdReg(`PMC_REG_PON, 8'h04);
    cyc(2100);
    chk({4'h0, mode}, 8'h04);
    // thermal shutdown wins over adapter wake
    tShut = 1;
    waitMode(4'h2);
    adp = 1;
    cyc(40);
    chk({4'h0, mode}, 8'h02);
    tShut = 0;
    waitMode(4'h4);
    cyc(2);
    chk({7'h0, chgEn}, 8'h01);
    rdReg(`PMC_REG_PON, 8'h02);
    ackPin = 0;
    waitMode(4'h8);
    cyc(2);
    chk({5'h0, chgEn, regEn, resetOeN}, 8'h04);
    adp = 0;
    waitMode(4'h2);
    usb = 1;
    waitMode(4'h4);
    rdReg(`PMC_REG_PON, 8'h01);
    finish_test();
  end
endmodule // tb
